// ===== src/key_wake_interrupt.sv
`timescale 1ns/1ps

`include "key_wake_defs.svh"

module key_wake_interrupt
  import key_wake_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  wire logic [NUM_PINS-1:0] wake_input_pin,
  input  wire logic                deep_stop,
  output logic                     key_irq,
  output logic                     wake_request,
  output logic                     irq
);

  // Reset and deep-stop share one path: waking leaves reset state
  logic block_rst;
  assign block_rst = rst | deep_stop;

  // Synchronised pin levels
  logic [NUM_PINS-1:0] pin_level;

  pin_sync #(
    .WIDTH    (NUM_PINS)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst      (block_rst),
    .async_in (wake_input_pin),
    .sync_out (pin_level)
  );

  // Configuration state
  logic [NUM_PINS-1:0] pin_enable;
  logic [NUM_PINS-1:0] polarity;
  logic                sense_mode;
  logic                request_enable;
  logic                detect_flag;
  logic [NUM_PINS-1:0] next_pin_enable;
  logic [NUM_PINS-1:0] next_polarity;
  logic                next_sense_mode;
  logic                next_request_enable;
  logic                next_detect_flag;

  // Event interrupt state
  logic [`EV_COUNT-1:0] irq_status;
  logic [`EV_COUNT-1:0] irq_enable;
  logic [`EV_COUNT-1:0] next_irq_status;
  logic [`EV_COUNT-1:0] next_irq_enable;
  logic [`EV_COUNT-1:0] event_set;
  logic [`EV_COUNT-1:0] event_clear;

  // Bus state
  bus_state_e  bus_state;
  bus_state_e  next_bus_state;
  logic        next_waitrequest;
  logic [31:0] next_readdata;
  logic        wr_take;

  // Detection outputs
  logic edge_hit;
  logic level_hit;
  logic any_asserted;

  // Request outputs
  logic next_key_irq;
  logic next_wake_request;
  logic next_irq;

  // Decode helpers used by read and write paths
  function automatic logic hit(input logic [4:0] a,
                               input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pads an 8-bit-or-narrower field to a bus word
  function automatic logic [31:0] pad_word(input logic [7:0] v);
    pad_word = {24'h00_0000, v};
  endfunction

  // Detection runs on every cycle regardless of wait or debug state
  edge_level_detect #(
    .NUM_PINS     (NUM_PINS)
  ) u_detect (
    .mclk         (mclk),
    .rst          (block_rst),
    .pin_level    (pin_level),
    .pin_enable   (pin_enable),
    .polarity     (polarity),
    .sense_mode   (sense_mode),
    .edge_hit     (edge_hit),
    .level_hit    (level_hit),
    .any_asserted (any_asserted)
  );

  // Write strobe: taken only in the cycle waitrequest is low
  // A write with byteenable[0] low is still acknowledged, then dropped
  assign wr_take = (bus_state == bus_ack) & write & byteenable[0];

  // Bus handshake: one wait cycle, then a single acknowledge cycle
  // Read data is captured as the request is seen, so it stands for the
  // whole acknowledge cycle; a read never waits on a slow source
  always_comb
  begin
    next_bus_state   = bus_state;
    next_waitrequest = 1'b1;
    next_readdata    = readdata;
    case (bus_state)
      bus_idle:
      begin
        if (read | write)
        begin
          next_bus_state   = bus_ack;
          next_waitrequest = 1'b0;
          next_readdata    = `RST_WORD;
          if (read)
          begin
            if (hit(address, `OFS_KEY_STATUS_CONTROL))
              next_readdata = pad_word({4'h0, detect_flag, 1'b0,
                                        request_enable,
                                        sense_mode});
            else if (hit(address, `OFS_PIN_ENABLE))
              next_readdata = pad_word(8'(pin_enable));
            else if (hit(address, `OFS_POLARITY))
              next_readdata = pad_word(8'(polarity));
            else if (hit(address, `OFS_IRQ_STATUS))
              next_readdata = pad_word(8'(irq_status));
            else if (hit(address, `OFS_IRQ_ENABLE))
              next_readdata = pad_word(8'(irq_enable));
            else if (hit(address, `OFS_PIN_LEVEL))
              next_readdata = pad_word(8'(pin_level));
          end
        end
      end
      bus_ack:
      begin
        next_bus_state   = bus_idle;
        next_waitrequest = 1'b1;
      end
      default:
      begin
        next_bus_state   = bus_idle;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (block_rst)
    begin
      bus_state   <= bus_idle;
      waitrequest <= 1'b1;
      readdata    <= `RST_WORD;
    end
    else
    begin
      bus_state   <= next_bus_state;
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
    end
  end

  // Configuration registers; flag ignores writes except acknowledge
  always_comb
  begin
    next_pin_enable     = pin_enable;
    next_polarity       = polarity;
    next_sense_mode     = sense_mode;
    next_request_enable = request_enable;
    next_detect_flag    = detect_flag;
    event_set           = `RST_EVENTS;
    if (wr_take && hit(address, `OFS_PIN_ENABLE))
      next_pin_enable = writedata[NUM_PINS-1:0];
    if (wr_take && hit(address, `OFS_POLARITY))
      next_polarity = writedata[NUM_PINS-1:0];
    if (wr_take && hit(address, `OFS_KEY_STATUS_CONTROL))
    begin
      next_sense_mode     = writedata[`SC_SENSE_MODE_BIT];
      next_request_enable = writedata[`SC_REQUEST_ENABLE_BIT];
      if (writedata[`SC_ACKNOWLEDGE_BIT])
      begin
        // Level mode holds the flag while any enabled pin is asserted
        if (sense_mode && any_asserted)
          event_set[`EV_ACK_REFUSED_BIT] = 1'b1;
        else
          next_detect_flag = 1'b0;
      end
    end
    // Set after clear so a coincident event is never lost
    // In level mode this re-sets the flag every cycle the level stands
    if (edge_hit || level_hit)
    begin
      next_detect_flag = 1'b1;
      if (!detect_flag)
        event_set[`EV_DETECT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (block_rst)
    begin
      pin_enable     <= '0;
      polarity       <= '0;
      sense_mode     <= 1'b0;
      request_enable <= 1'b0;
      detect_flag    <= 1'b0;
    end
    else
    begin
      pin_enable     <= next_pin_enable;
      polarity       <= next_polarity;
      sense_mode     <= next_sense_mode;
      request_enable <= next_request_enable;
      detect_flag    <= next_detect_flag;
    end
  end

  // Sticky event status with write-one clear; set beats clear
  // A refused acknowledge is its own event so software can see it
  always_comb
  begin
    event_clear     = `RST_EVENTS;
    next_irq_enable = irq_enable;
    if (wr_take && hit(address, `OFS_IRQ_CLEAR))
      event_clear = writedata[`EV_COUNT-1:0];
    if (wr_take && hit(address, `OFS_IRQ_ENABLE))
      next_irq_enable = writedata[`EV_COUNT-1:0];
    next_irq_status = (irq_status & ~event_clear) | event_set;
  end

  always_ff @(posedge mclk)
  begin
    if (block_rst)
    begin
      irq_status <= `RST_EVENTS;
      irq_enable <= `RST_EVENTS;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  // Registered request outputs, one cycle behind the flag; irq one cycle behind the event status
  // Stop3 assumes mclk keeps running; a clockless wake would need a latch
  always_comb
  begin
    next_key_irq      = detect_flag & request_enable;
    // Wake from wait or stop3 follows the same gated request
    next_wake_request = detect_flag & request_enable;
    next_irq          = |(irq_status & irq_enable);
  end

  always_ff @(posedge mclk)
  begin
    if (block_rst)
    begin
      key_irq      <= 1'b0;
      wake_request <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      key_irq      <= next_key_irq;
      wake_request <= next_wake_request;
      irq          <= next_irq;
    end
  end

endmodule // key_wake_interrupt

// ===== inc/key_wake_defs.svh
`ifndef KEY_WAKE_DEFS_SVH
`define KEY_WAKE_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define OFS_KEY_STATUS_CONTROL  5'h00
`define OFS_PIN_ENABLE          5'h04
`define OFS_POLARITY            5'h08
`define OFS_IRQ_STATUS          5'h0C
`define OFS_IRQ_CLEAR           5'h10
`define OFS_IRQ_ENABLE          5'h14
`define OFS_PIN_LEVEL           5'h18

// Field positions in key_status_control
`define SC_SENSE_MODE_BIT       0
`define SC_REQUEST_ENABLE_BIT   1
`define SC_ACKNOWLEDGE_BIT      2
`define SC_DETECT_FLAG_BIT      3

// Field positions in the event status, clear and enable registers
`define EV_DETECT_BIT           0
`define EV_ACK_REFUSED_BIT      1
`define EV_COUNT                2

// Reset values
`define RST_BYTE                8'h00
`define RST_EVENTS              2'h0
`define RST_WORD                32'h0000_0000

`endif

// ===== inc/key_wake_pkg.sv
package key_wake_pkg;

  // Avalon slave handshake states, one-hot
  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_ack  = 2'b10
  } bus_state_e;

endpackage

// ===== src/pin_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for asynchronous pin levels
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // First stage feeds only the second stage
  always_comb
  begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule // pin_sync

// ===== src/edge_level_detect.sv
`timescale 1ns/1ps

// Per-pin assertion, edge recognition with re-arm, and level sense
module edge_level_detect #(
  parameter int NUM_PINS = 8
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [NUM_PINS-1:0] pin_level,
  input  wire logic [NUM_PINS-1:0] pin_enable,
  input  wire logic [NUM_PINS-1:0] polarity,
  input  wire logic                sense_mode,
  output logic                     edge_hit,
  output logic                     level_hit,
  output logic                     any_asserted
);

  logic [NUM_PINS-1:0] asserted;
  logic [NUM_PINS-1:0] prev_asserted;
  logic [NUM_PINS-1:0] next_prev_asserted;
  logic                armed;
  logic                next_armed;

  // Polarity 0 means low is asserted, 1 means high is asserted
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_pin
      assign asserted[g] = pin_enable[g] & ~(pin_level[g] ^ polarity[g]);
    end
  endgenerate

  // Edge needs a deasserted sample then an asserted one, while armed
  always_comb
  begin
    any_asserted       = |asserted;
    edge_hit           = armed & |(asserted & ~prev_asserted);
    level_hit          = sense_mode & any_asserted;
    next_prev_asserted = asserted;
    next_armed         = armed;
    if (edge_hit)
      next_armed = 1'b0;
    if (!any_asserted)
      next_armed = 1'b1;
  end

  // Starts unarmed, arms once no enabled pin is asserted, so a pin asserted as it is enabled is an edge
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prev_asserted <= '0;
      armed         <= 1'b0;
    end
    else
    begin
      prev_asserted <= next_prev_asserted;
      armed         <= next_armed;
    end
  end

endmodule // edge_level_detect

// ===== bench/key_wake_properties.sv
`timescale 1ns/1ps
`include "key_wake_defs.svh"

// Port-level checks beside the key wake unit
module key_wake_properties (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        deep_stop,
  input wire logic        key_irq,
  input wire logic        wake_request,
  input wire logic        irq
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_wake;
    wake_request == key_irq;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request differs from key request");

  property p_ack_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("waitrequest low for more than one cycle");

  property p_answer;
    (read || write) && waitrequest |-> ##[1:2] !waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus request not answered");

  property p_no_req;
    !read && !write && waitrequest |=> waitrequest;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("answer without a request");

  // Unused and acknowledge bits never read back
  property p_sc_zero;
    read && !waitrequest && address == `OFS_KEY_STATUS_CONTROL
      |-> readdata[7:4] == 4'h0 && !readdata[2];
  endproperty
  a_sc_zero: assert property (p_sc_zero)
    else $error("status control reads nonzero fixed bits");

  // The request only drops after a register write, a reset or a deep stop
  property p_fall;
    $fell(key_irq) |-> $past(write) || $past(write, 2) ||
      $past(deep_stop) || $past(deep_stop, 2) || $past(rst);
  endproperty
  a_fall: assert property (p_fall)
    else $error("key request dropped without cause");

  property p_stop;
    deep_stop |=> waitrequest && !key_irq && !irq;
  endproperty
  a_stop: assert property (p_stop)
    else $error("outputs active during deep stop");

  property p_reset;
    $fell(rst) |-> waitrequest && !key_irq && !irq;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not idle after reset");
endmodule // key_wake_properties

bind key_wake_interrupt key_wake_properties prop_u (
  .mclk, .rst, .address, .read, .write, .readdata, .waitrequest,
  .deep_stop, .key_irq, .wake_request, .irq
);

// ===== bench/key_wake_pins.sv
`timescale 1ns/1ps

// Switches on the shared pins; contacts change only on a clock edge
module key_wake_pins (
  input  wire logic       mclk,
  input  wire logic [7:0] want,
  output logic      [7:0] pin
);
  // Registered so a press reaches pin only at a clock edge, after that edge's sampling
  always_ff @(posedge mclk)
    pin <= want;
endmodule // key_wake_pins

// ===== bench/key_wake_interrupt_tb_top.sv
`timescale 1ns/1ps
`include "key_wake_defs.svh"

module key_wake_interrupt_tb_top;
  localparam logic [4:0] SC = `OFS_KEY_STATUS_CONTROL;
  logic        mclk, rst, read, write, deep_stop;
  logic        waitrequest, key_irq, wake_request, irq;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, q;
  logic [7:0]  want, pin;
  int          error_cnt, cmp_count;

  key_wake_pins pins_u (.mclk(mclk), .want(want), .pin(pin));
  key_wake_interrupt dut_u (
    .mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .wake_input_pin(pin), .deep_stop(deep_stop), .key_irq(key_irq),
    .wake_request(wake_request), .irq(irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic [3:0] e);
    int n;
    n = 0;
    @(posedge mclk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= e;
    do
    begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(q, {24'h00_0000, e});
  endtask

  // Enough edges for switch, synchroniser and registered outputs
  task automatic press(input logic [7:0] v);
    @(posedge mclk);
    want <= v;
    repeat (6) @(posedge mclk);
  endtask

  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask

  initial
  begin
    {read, write, deep_stop} = 3'h0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    want = 8'hFF;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(SC, 8'h00);
    rd(`OFS_PIN_ENABLE, 8'h00);
    rd(`OFS_POLARITY, 8'h00);
    rd(5'h1C, 8'h00);
    wr(SC, 8'hFF);
    rd(SC, 8'h03);
    bus(1'b1, SC, 8'h00, 4'hE);
    rd(SC, 8'h03);
    wr(SC, 8'h02);
    wr(`OFS_PIN_ENABLE, 8'h0F);
    press(8'hEF);
    rd(SC, 8'h02);
    press(8'hEE);
    rd(SC, 8'h0A);
    chk({31'h0, key_irq}, 32'h0000_0001);
    chk({31'h0, wake_request}, 32'h0000_0001);
    wr(SC, 8'h06);
    rd(SC, 8'h02);
    press(8'hEC);
    rd(SC, 8'h02);
    press(8'hFF);
    press(8'hFD);
    rd(SC, 8'h0A);
    rd(`OFS_PIN_LEVEL, 8'hFD);
    // Level mode first, then an acknowledge while pin one is held down
    wr(SC, 8'h03);
    wr(SC, 8'h07);
    rd(SC, 8'h0B);
    rd(`OFS_IRQ_STATUS, 8'h03);
    wr(`OFS_IRQ_ENABLE, 8'h02);
    settle();
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    settle();
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`OFS_IRQ_CLEAR, 8'h03);
    rd(`OFS_IRQ_STATUS, 8'h00);
    wr(SC, 8'h01);
    settle();
    chk({31'h0, key_irq}, 32'h0000_0000);
    rd(SC, 8'h09);
    // Rising polarity on pin zero
    press(8'hFE);
    wr(`OFS_POLARITY, 8'h01);
    wr(SC, 8'h06);
    rd(SC, 8'h02);
    press(8'hFF);
    rd(SC, 8'h0A);
    wr(`OFS_PIN_ENABLE, 8'h00);
    wr(SC, 8'h06);
    press(8'h00);
    rd(SC, 8'h02);
    @(posedge mclk);
    deep_stop <= 1'b1;
    settle();
    deep_stop <= 1'b0;
    rd(SC, 8'h00);
    rd(`OFS_POLARITY, 8'h00);
    end_of_test();
  end
endmodule // key_wake_interrupt_tb_top
